// >>> burst_sram_consts.svh
// constants for the flow-through burst static ram
// assumes one clock; included by bare name from package and modules
// Contract
// [RULE_01] register address, data, controls; not oe/order
// [RULE_02] array: 128K words of 36 bits
// [RULE_03] two-bit internal counter on lowest address bits
// [RULE_04] active advance steps the burst count once
// [RULE_05] order select low linear, high interleaved
// [RULE_06] host holds order select fixed
// [RULE_07] controller strobe aborts burst, loads address
// [RULE_08] processor strobe loads; no deselect when primary high
// [RULE_09] primary enable high blocks proc, ctrl deselects
// [RULE_10] second chip enable active high
// [RULE_11] third chip enable active low
// [RULE_12] one byte select per byte lane
// [RULE_13] write enable writes only selected lanes
// [RULE_14] global write or all selects writes all
// [RULE_15] writes start on clock edge, self-timed
// [RULE_16] read data flows without output register stage
// [RULE_17] output enable asynchronous, low drives pins
// [RULE_18] host wires counter bits to address lsbs
// [RULE_19] byte-only host: global high, enable low
// [RULE_20] linear adds count, interleaved xors count
// [RULE_21] registered deselect stops read drive next cycle
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH

`define SRAM_ADDR_W      17
`define SRAM_DEPTH       131072
`define SRAM_LANES       4
`define SRAM_LANE_W      9
`define SRAM_WORD_W      36
`define SRAM_BURST_W     2
`define SRAM_ORDER_LIN   1'b0
`define SRAM_ORDER_INTLV 1'b1
`define SRAM_ALL_LANES   4'hf
`define SRAM_NO_LANES    4'h0
`define SRAM_CNT_START   2'h0
`define SRAM_CNT_STEP    2'h1

`endif

// >>> burst_sram_pkg.sv
// types shared by the burst static ram modules
// assumes the constants header sits in the same folder
`default_nettype none
`include "burst_sram_consts.svh"

package burst_sram_pkg;
   typedef enum logic {ST_DESEL, ST_ACTIVE} sel_state_t;
   typedef logic [`SRAM_LANES-1:0] lane_mask_t;
   typedef logic [`SRAM_BURST_W-1:0] burst_cnt_t;
endpackage

`default_nettype wire

// >>> word_store.sv
// lane-split storage array with a registered read port
// assumes writes and reads are issued by the controller on one clock
`default_nettype none
`include "burst_sram_consts.svh"

module word_store #(
   parameter int DEPTH  = `SRAM_DEPTH,
   parameter int AW     = `SRAM_ADDR_W,
   parameter int LANES  = `SRAM_LANES,
   parameter int LW     = `SRAM_LANE_W
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [LANES-1:0]    we,
   input  wire logic [AW-1:0]       waddr,
   input  wire logic [LANES*LW-1:0] wdata,
   input  wire logic                re,
   input  wire logic [AW-1:0]       raddr,
   output var  logic [LANES*LW-1:0] rdata
);
   // ==========================================
   // per-lane arrays
   // write-first per lane so a read of the address being written sees new data
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LW-1:0] mem [DEPTH];
         // one owner per lane register, so no slice has two writers
         logic [LW-1:0] rd_r;
         always_ff @(posedge clk) begin
            if (we[g]) begin // RULE_15 RULE_12
               mem[waddr] <= wdata[g*LW +: LW];
            end
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               rd_r <= '0;
            end else if (re) begin // RULE_16
               if (we[g] && waddr == raddr) begin
                  rd_r <= wdata[g*LW +: LW];
               end else begin
                  rd_r <= mem[raddr];
               end
            end
         end
         assign rdata[g*LW +: LW] = rd_r;
      end
   endgenerate
endmodule

`default_nettype wire

// >>> burst_sram.sv
// synchronous burst static ram, flow-through reads, self-timed writes
// assumes the host drives clk and all inputs synchronous to it
`default_nettype none
`include "burst_sram_consts.svh"

module burst_sram #(
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int DEPTH  = `SRAM_DEPTH
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [ADDR_W-3:0]             addr_in,
   input  wire logic [1:0]                    burst_addr_lsbs,
   input  wire logic                          ctrl_addr_strobe_n,
   input  wire logic                          proc_addr_strobe_n,
   input  wire logic                          burst_advance_n,
   input  wire logic                          burst_order_sel,
   input  wire logic                          chip_en_primary_n,
   input  wire logic                          chip_en_high,
   input  wire logic                          chip_en_low_n,
   input  wire burst_sram_pkg::lane_mask_t    byte_write_sel_n,
   input  wire logic                          global_write_n,
   input  wire logic                          write_en_n,
   input  wire logic                          output_en_n,
   input  wire logic [`SRAM_WORD_W-1:0]       data_lane_in,
   output var  logic [`SRAM_WORD_W-1:0]       data_lane_out,
   output var  logic                          data_lane_oe
);
   import burst_sram_pkg::*;

   // ==========================================
   // registered access state
   sel_state_t                state_r;
   sel_state_t                state_nxt;
   logic [ADDR_W-3:0]         hi_r;
   logic [ADDR_W-3:0]         hi_nxt;
   burst_cnt_t                base_r;
   burst_cnt_t                base_nxt;
   burst_cnt_t                cnt_r;
   burst_cnt_t                cnt_nxt;
   burst_cnt_t                low_nxt;
   logic [ADDR_W-1:0]         addr_r;
   lane_mask_t                wr_r;
   lane_mask_t                wr_nxt;
   lane_mask_t                lanes_req;
   logic [`SRAM_WORD_W-1:0]   wdata_r;
   logic                      rd_active_r;
   logic                      rd_nxt;
   logic                      sel_ok;
   logic                      proc_start;
   logic                      ctrl_start;
   logic                      load;

   // ==========================================
   // start decode
   always_comb begin
      sel_ok     = !chip_en_primary_n && chip_en_high && !chip_en_low_n; // RULE_10 RULE_11
      // primary enable high masks the processor strobe entirely
      proc_start = !proc_addr_strobe_n && !chip_en_primary_n; // RULE_08 RULE_09
      ctrl_start = !ctrl_addr_strobe_n && !proc_start; // RULE_07
      load       = proc_start || ctrl_start;
   end

   // ==========================================
   // write lane request
   always_comb begin
      if (!global_write_n) begin
         lanes_req = `SRAM_ALL_LANES; // RULE_14
      end else if (!write_en_n) begin
         lanes_req = ~byte_write_sel_n; // RULE_13 RULE_12
      end else begin
         lanes_req = `SRAM_NO_LANES;
      end
   end

   // ==========================================
   // next access
   always_comb begin
      state_nxt = state_r;
      hi_nxt    = hi_r;
      base_nxt  = base_r;
      cnt_nxt   = cnt_r;
      if (load) begin // RULE_07 RULE_08
         state_nxt = sel_ok ? ST_ACTIVE : ST_DESEL; // RULE_09
         hi_nxt    = addr_in;
         base_nxt  = burst_addr_lsbs;
         cnt_nxt   = `SRAM_CNT_START;
      end else if (state_r == ST_ACTIVE && !burst_advance_n) begin
         cnt_nxt   = burst_cnt_t'(cnt_r + `SRAM_CNT_STEP); // RULE_03 RULE_04
      end
      // order select is live, never registered
      if (burst_order_sel == `SRAM_ORDER_INTLV) begin // RULE_05
         low_nxt = base_nxt ^ cnt_nxt; // RULE_20
      end else begin
         low_nxt = burst_cnt_t'(base_nxt + cnt_nxt); // RULE_20
      end
      // a processor-started cycle never writes; it reads unless deselected
      if (state_nxt == ST_ACTIVE && !proc_start) begin
         wr_nxt = lanes_req;
      end else begin
         wr_nxt = `SRAM_NO_LANES;
      end
      rd_nxt = (state_nxt == ST_ACTIVE) && (wr_nxt == `SRAM_NO_LANES);
   end

   // ==========================================
   // input capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_DESEL;
         hi_r    <= '0;
         base_r  <= `SRAM_CNT_START;
         cnt_r   <= `SRAM_CNT_START;
         addr_r  <= '0;
      end else begin // RULE_01
         state_r <= state_nxt;
         hi_r    <= hi_nxt;
         base_r  <= base_nxt;
         cnt_r   <= cnt_nxt;
         addr_r  <= {hi_nxt, low_nxt};
      end
   end

   // write is performed at the edge after capture, no external pulse needed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_r    <= `SRAM_NO_LANES;
         wdata_r <= '0;
      end else begin
         wr_r    <= wr_nxt; // RULE_15
         wdata_r <= data_lane_in; // RULE_01
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_active_r <= 1'b0;
      end else begin
         rd_active_r <= rd_nxt; // RULE_21
      end
   end

   // output enable must stay asynchronous, hence the one gate after the flop
   assign data_lane_oe = rd_active_r && !output_en_n; // RULE_17

   // ==========================================
   // storage; read issued on the captured address so data lands with it
   word_store #(
      .DEPTH (DEPTH),
      .AW    (ADDR_W),
      .LANES (`SRAM_LANES),
      .LW    (`SRAM_LANE_W)
   ) u_store (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_r),
      .waddr (addr_r),
      .wdata (wdata_r),
      .re    (rd_nxt), // RULE_16 RULE_02
      .raddr ({hi_nxt, low_nxt}),
      .rdata (data_lane_out)
   );

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic ctrl_wr_start;
   assign ctrl_wr_start = ctrl_start && sel_ok;

   property p_desel_stop;
      (load && !sel_ok) |=> !rd_active_r ##1 (!rd_active_r || $past(load));
   endproperty
   a_desel_stop: assert property (p_desel_stop) else $error("read drive after deselect"); // RULE_21

   property p_ctrl_desel;
      (!ctrl_addr_strobe_n && chip_en_primary_n) |=> state_r == ST_DESEL && wr_r == 4'h0;
   endproperty
   a_ctrl_desel: assert property (p_ctrl_desel) else $error("ctrl strobe did not deselect"); // RULE_09

   property p_proc_blocked;
      (!proc_addr_strobe_n && chip_en_primary_n && ctrl_addr_strobe_n)
         |=> state_r == $past(state_r) && addr_r[ADDR_W-1:2] == $past(addr_r[ADDR_W-1:2]);
   endproperty
   a_proc_blocked: assert property (p_proc_blocked) else $error("proc strobe not ignored"); // RULE_08

   property p_load_addr;
      load |=> addr_r == {$past(addr_in), $past(burst_addr_lsbs)};
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("new address not loaded"); // RULE_07

   property p_lin_step;
      (state_r == ST_ACTIVE && !load && !burst_advance_n && !burst_order_sel)
         |=> addr_r[1:0] == 2'($past(addr_r[1:0]) + 2'h1);
   endproperty
   a_lin_step: assert property (p_lin_step) else $error("linear step wrong"); // RULE_04

   property p_intlv_step;
      (state_r == ST_ACTIVE && !load && !burst_advance_n && burst_order_sel)
         |=> addr_r[1:0] == ($past(base_r) ^ 2'($past(cnt_r) + 2'h1));
   endproperty
   a_intlv_step: assert property (p_intlv_step) else $error("interleaved step wrong"); // RULE_05

   property p_global_wr;
      (ctrl_wr_start && !global_write_n) |=> wr_r == 4'hf;
   endproperty
   a_global_wr: assert property (p_global_wr) else $error("global write missed lanes"); // RULE_14

   property p_byte_wr;
      (ctrl_wr_start && global_write_n && !write_en_n) |=> wr_r == ~$past(byte_write_sel_n);
   endproperty
   a_byte_wr: assert property (p_byte_wr) else $error("byte lanes wrong"); // RULE_13

   property p_hold_hi;
      !load |=> addr_r[ADDR_W-1:2] == $past(addr_r[ADDR_W-1:2]);
   endproperty
   a_hold_hi: assert property (p_hold_hi) else $error("upper address moved in burst"); // RULE_03

   c_burst4: cover property (load && sel_ok ##1 (!burst_advance_n && !load) [*3]);
   c_write: cover property (ctrl_wr_start && !write_en_n);
   c_desel: cover property (state_r == ST_ACTIVE ##1 state_r == ST_DESEL);
   c_intlv: cover property (burst_order_sel && state_r == ST_ACTIVE && !burst_advance_n);
endmodule

`default_nettype wire

// >>> bus_host_model.sv
// host-side model of the shared data lanes between the host and the memory
// assumes the memory drives the lanes only while its drive enable is high
`default_nettype none

module bus_host_model (
   input  wire logic [35:0] drv_data,
   input  wire logic        drv_en,
   output var  logic [35:0] bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [35:0] last_r;
   // ==========================================
   // lane resolution
   // released lanes show the inverse, so a stale value never passes
   always @* begin
      if (drv_en) begin
         bus = drv_data;
         last_r = drv_data;
      end else begin
         bus = ~last_r;
      end
   end
endmodule

`default_nettype wire

// >>> testbench.sv
// bench for the burst static ram: driver notes expected reads, monitor compares
// assumes the design files and bus_host_model are compiled before it
`default_nettype none
`include "burst_sram_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import burst_sram_pkg::*;
   logic        clk, rst_n, cs_n, ps_n, adv_n, order, gw_n, we_n, oe_n, doe;
   logic [2:0]  en;
   logic [5:0]  a_hi;
   logic [1:0]  a_lo;
   lane_mask_t  sel_n;
   logic [35:0] din, dout, bus;
   logic [35:0] mem [256];
   logic [35:0] expq [$];
   logic [7:0]  base;
   int          fails, tests_run;

   burst_sram #(.ADDR_W(8), .DEPTH(256)) dut (.clk(clk), .rst_n(rst_n), .addr_in(a_hi),
      .burst_addr_lsbs(a_lo), .ctrl_addr_strobe_n(cs_n), .proc_addr_strobe_n(ps_n),
      .burst_advance_n(adv_n), .burst_order_sel(order), .chip_en_primary_n(en[2]),
      .chip_en_high(en[1]), .chip_en_low_n(en[0]), .byte_write_sel_n(sel_n),
      .global_write_n(gw_n), .write_en_n(we_n), .output_en_n(oe_n),
      .data_lane_in(din), .data_lane_out(dout), .data_lane_oe(doe));
   bus_host_model host (.drv_data(dout), .drv_en(doe), .bus(bus));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // checking and verdict
   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // any drive with no read noted is a fault, e.g. a deselect that did not stop
   always @(negedge clk) begin
      if (rst_n && doe === 1'b1) begin
         if (expq.size() == 0) check("stray drive", 36'h1, 36'h0);
         else check("read data", bus, expq.pop_front());
      end
   end

   // ==========================================
   // bus cycles
   task automatic cyc(input logic c, p, v, input logic [7:0] a, input logic w, g,
                      input lane_mask_t s, input logic [35:0] d, input logic [2:0] e);
      @(posedge clk);
      cs_n <= c; ps_n <= p; adv_n <= v; we_n <= w; gw_n <= g; sel_n <= s; din <= d; en <= e;
      a_hi <= a[7:2];
      a_lo <= a[1:0];
   endtask

   // write then deselect; byte-only writes keep global high, enable low
   task automatic wr(input logic [7:0] a, input logic g, input lane_mask_t s);
      logic [35:0] d;
      d = 36'({$urandom, $urandom});
      cyc(1'b0, 1'b1, 1'b1, a, 1'b0, g, s, d, 3'b010);
      for (int i = 0; i < 4; i++)
         if (!g || !s[i]) mem[a][i*9+:9] = d[i*9+:9];
      cyc(1'b0, 1'b1, 1'b1, a, 1'b1, 1'b1, 4'hf, 36'h0, 3'b000);
   endtask

   // beat 2 carries a processor strobe with primary enable high: must be ignored
   task automatic rd(input logic [7:0] a, input int n, input logic pst, input logic [2:0] e,
                     input logic tri_chk);
      logic [7:0] ad;
      for (int k = 0; k < n; k++) begin
         ad = {a[7:2], order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
         expq.push_back(mem[ad]);
         if (k == 0) cyc(pst, !pst, 1'b1, a, 1'b1, 1'b1, 4'hf, 36'h0, 3'b010);
         else cyc(1'b1, k != 2, 1'b0, 8'h0, 1'b1, 1'b1, 4'hf, 36'h0,
                  k == 2 ? 3'b110 : 3'b010);
      end
      cyc(1'b0, 1'b1, 1'b1, a, 1'b1, 1'b1, 4'hf, 36'h0, e);
      if (tri_chk) begin
         #2 oe_n = 1'b1;
         #1 check("drive while output disabled", {35'h0, doe}, 36'h0);
         oe_n = 1'b0;
      end
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      give_verdict();
   end

   // ==========================================
   // main sequence
   initial begin
      rst_n = 1'b0; cs_n = 1'b1; ps_n = 1'b1; adv_n = 1'b1; order = 1'b0; gw_n = 1'b1;
      we_n = 1'b1; oe_n = 1'b0; en = 3'b010; a_hi = 6'h0; a_lo = 2'h0; sel_n = 4'hf;
      din = 36'h0;
      void'($urandom(55));
      for (int o = 0; o < 2; o++) begin
         @(posedge clk);
         rst_n <= 1'b0;
         order <= o[0];
         repeat (8) @(posedge clk);
         rst_n <= 1'b1;
         base = {6'($urandom), 2'h0};
         for (int i = 0; i < 4; i++) wr(base + 8'(i), 1'b0, 4'($urandom));
         wr(base + 8'h1, 1'b1, 4'($urandom % 15));
         wr(base + 8'h2, 1'b1, 4'h0);
         rd(base + 8'($urandom % 4), 4, 1'b0, 3'b000, 1'b1);
         rd(base + 8'h1, 5, 1'b1, 3'b110, 1'b0);
         rd(base + 8'h3, 1, 1'b0, 3'b011, 1'b0);
         cyc(1'b1, 1'b0, 1'b1, base, 1'b1, 1'b1, 4'hf, 36'h0, 3'b110);
         repeat (3) cyc(1'b1, 1'b1, 1'b1, 8'h0, 1'b1, 1'b1, 4'hf, 36'h0, 3'b010);
      end
      check("unanswered reads", 36'(expq.size()), 36'h0);
      give_verdict();
   end
endmodule

`default_nettype wire
